// File: rtl/lns_link_node.sv
// Link node configuration registers and communication supervision
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lns_link_node #(
  parameter int TICK_CYCLES = lns_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Register port
  input  wire logic [lns_pkg::AW-1:0] reg_addr,
  input  wire logic [lns_pkg::DW-1:0] reg_wdata,
  input  wire logic                reg_we,
  input  wire logic                reg_re,
  output var  logic [lns_pkg::DW-1:0] reg_rdata,
  // Received messages from the link controller
  input  wire logic                rx_valid,
  input  wire logic [5:0]          rx_node,
  // Link board presence pin
  input  wire logic                board_present,
  // Results
  output var  logic                trip,
  output var  logic                irq,
  output var  logic                station_active,
  output var  logic [5:0]          station_node_id,
  output var  lns_pkg::lns_rate_t  link_bit_rate_select
);
  import lns_pkg::*;

  typedef struct packed {
    logic [5:0]   station;
    lns_rate_t    rate;
    logic [15:0]  tp_to;
    logic [5:0]   tp_slave;
    logic [15:0]  fx_to;
    logic [5:0]   m1_node;
    logic [5:0]   m2_node;
    lns_fx_type_t m1_type;
    logic [2:0]   ctrl;
    logic [NEV-1:0] flags;
    logic [NEV-1:0] int_en;
    logic [DW-1:0] rdata;
    logic [1:0]   board_sync;
    logic         irq;
    logic         trip;
    logic         active;
  } lns_st_t;

  lns_st_t s_q;
  lns_st_t s_d;

  logic           tick;
  logic           tp_run;
  logic           tp_kick;
  logic           tp_exp;
  logic           m1_run;
  logic           m1_kick;
  logic           m1_exp;
  logic           m2_run;
  logic           m2_kick;
  logic           m2_exp;
  logic           m1_used;
  logic           board_lost;
  logic [NEV-1:0] events;
  logic [NEV-1:0] clr;
  logic [DW-1:0]  fw1;
  logic [DW-1:0]  fw2;
  logic [DW-1:0]  fw3;

  lns_ms_tick #(
    .CYCLES  (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick)
  );

  // Supervision enables and message matching
  always_comb begin
    tp_run  = s_q.ctrl[C_TP_MASTER] && s_q.tp_slave != NODE_OFF;
    tp_kick = rx_valid && rx_node == s_q.tp_slave;
    m1_used = s_q.m1_type == LNS_FX_EXTERN
              && s_q.m1_node != NODE_OFF;
    m1_run  = s_q.ctrl[C_ARM_CONV] && m1_used;
    m1_kick = rx_valid && rx_node == s_q.m1_node;
    m2_run  = s_q.ctrl[C_ARM_CONV] && s_q.m2_node != NODE_OFF;
    m2_kick = rx_valid && rx_node == s_q.m2_node;
  end

  // Timers force to zero on a 0 ms limit, so the fault never fires
  lns_timeout u_tp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick),
    .run     (tp_run),
    .kick    (tp_kick),
    .limit   (s_q.tp_to),
    .expired (tp_exp)
  );

  lns_timeout u_m1 (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick),
    .run     (m1_run),
    .kick    (m1_kick),
    .limit   (s_q.fx_to),
    .expired (m1_exp)
  );

  lns_timeout u_m2 (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick),
    .run     (m2_run),
    .kick    (m2_kick),
    .limit   (s_q.fx_to),
    .expired (m2_exp)
  );

  // Fault words assembled from the sticky flags
  always_comb begin
    fw1 = '0;
    fw2 = '0;
    fw3 = '0;
    fw1[FW1_BOARD] = s_q.flags[E_BOARD];
    fw1[FW1_M1]    = s_q.flags[E_M1];
    fw2[FW2_M2]    = s_q.flags[E_M2];
    fw3[FW3_TP]    = s_q.flags[E_TP];
  end

  always_comb begin
    board_lost = s_q.ctrl[C_BOARD_SEL] && !s_q.board_sync[1];
    events = '0;
    events[E_BOARD] = board_lost;
    events[E_TP]    = tp_exp;
    events[E_M1]    = m1_exp;
    events[E_M2]    = m2_exp;
    clr = '0;
    if (reg_we && reg_addr == A_INT_CLR) begin
      clr = reg_wdata[NEV-1:0];
    end
  end

  always_comb begin
    s_d = s_q;
    // Only bit 1 of the synchroniser feeds logic
    s_d.board_sync = {s_q.board_sync[0], board_present};
    // Set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~clr) | events;
    s_d.irq   = |(s_d.flags & s_q.int_en);
    s_d.trip  = s_d.flags[E_BOARD];
    s_d.active = s_q.station != NODE_OFF;
    if (reg_we) begin
      case (reg_addr)
        A_STATION: begin
          // Wider values are dropped, not folded onto a live id
          if (reg_wdata <= DW'(NODE_MAX)) begin
            s_d.station = reg_wdata[5:0];
          end
        end
        A_RATE: begin
          // Code 6 has no rate and is dropped
          if (lns_rate_t'(reg_wdata[2:0]) != LNS_RBAD) begin
            s_d.rate = lns_rate_t'(reg_wdata[2:0]);
          end
        end
        A_TP_TO: begin
          if (reg_wdata <= TO_MAX) begin
            s_d.tp_to = reg_wdata;
          end
        end
        A_TP_SLAVE: begin
          if (reg_wdata <= DW'(NODE_MAX)) begin
            s_d.tp_slave = reg_wdata[5:0];
          end
        end
        A_FX_TO: begin
          if (reg_wdata <= TO_MAX) begin
            s_d.fx_to = reg_wdata;
          end
        end
        A_M1_NODE: begin
          if (reg_wdata <= DW'(M1_NODE_MAX)) begin
            s_d.m1_node = reg_wdata[5:0];
          end
        end
        A_M2_NODE: begin
          if (reg_wdata <= DW'(NODE_MAX)) begin
            s_d.m2_node = reg_wdata[5:0];
          end
        end
        A_M1_TYPE: begin
          s_d.m1_type = lns_fx_type_t'(reg_wdata[1:0]);
        end
        A_CTRL: begin
          s_d.ctrl = reg_wdata[2:0];
        end
        A_INT_EN: begin
          s_d.int_en = reg_wdata[NEV-1:0];
        end
        default: begin
        end
      endcase
    end
    // Read data is valid only in the cycle after the strobe
    s_d.rdata = '0;
    if (reg_re) begin
      case (reg_addr)
        A_STATION:   s_d.rdata = DW'(s_q.station);
        A_RATE:      s_d.rdata = DW'(s_q.rate);
        A_TP_TO:     s_d.rdata = s_q.tp_to;
        A_TP_SLAVE:  s_d.rdata = DW'(s_q.tp_slave);
        A_FX_TO:     s_d.rdata = s_q.fx_to;
        A_M1_NODE:   s_d.rdata = DW'(s_q.m1_node);
        A_M2_NODE:   s_d.rdata = DW'(s_q.m2_node);
        A_M1_TYPE:   s_d.rdata = DW'(s_q.m1_type);
        A_CTRL:      s_d.rdata = DW'(s_q.ctrl);
        A_FW1:       s_d.rdata = fw1;
        A_FW2:       s_d.rdata = fw2;
        A_FW3:       s_d.rdata = fw3;
        A_INT_STAT:  s_d.rdata = DW'(s_q.flags);
        A_INT_EN:    s_d.rdata = DW'(s_q.int_en);
        A_LINK_STAT: s_d.rdata = DW'({m1_used, tp_run, s_q.board_sync[1]});
        default:     s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.station  <= STATION_RST;
      s_q.rate     <= LNS_R500K;
      s_q.tp_to    <= TO_RST;
      s_q.tp_slave <= TP_SLAVE_RST;
      s_q.fx_to    <= TO_RST;
      s_q.m1_node  <= M1_NODE_RST;
      s_q.m2_node  <= M2_NODE_RST;
      s_q.m1_type  <= LNS_FX_UNUSED;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata            = s_q.rdata;
  assign irq                  = s_q.irq;
  assign trip                 = s_q.trip;
  assign station_active       = s_q.active;
  assign station_node_id      = s_q.station;
  assign link_bit_rate_select = s_q.rate;
endmodule : lns_link_node
`default_nettype wire

// File: rtl/lns_pkg.sv
// Constants and types of the link node configuration and supervision block
// Notes on behaviour
// - Station node id takes 0 to 63, resets to 0, and 0 means inactive.
// - A selected but missing link board trips and sets fault word one bit 7.
// - Bit-rate codes 0..5 are 20/50/125/250/500/800 kbit/s, 7 is 1 Mbit/s.
// - Silence from the 12-pulse slave for the timeout sets word three bit 2.
// - The 12-pulse timeout runs only while acting as 12-pulse master.
// - A 12-pulse timeout of 0 ms suppresses that fault entirely.
// - The 12-pulse slave id takes 0 to 63, resets to 31, 0 is no slave.
// - Exciter silence sets word one bit 15 (motor 1) or word two bit 2.
// - Exciter timeouts run only as armature converter; 0 ms disables them.
// - Motor 1 exciter id takes 0 to 32, resets to 21, 0 is inactive.
// - Motor 1 exciter id is ignored when its type is unused or on-board.
package lns_pkg;

  localparam int          AW = 4;
  localparam int          DW = 16;

  // Register word addresses
  localparam logic [3:0]  A_STATION   = 4'h0;
  localparam logic [3:0]  A_RATE      = 4'h1;
  localparam logic [3:0]  A_TP_TO     = 4'h2;
  localparam logic [3:0]  A_TP_SLAVE  = 4'h3;
  localparam logic [3:0]  A_FX_TO     = 4'h4;
  localparam logic [3:0]  A_M1_NODE   = 4'h5;
  localparam logic [3:0]  A_M2_NODE   = 4'h6;
  localparam logic [3:0]  A_M1_TYPE   = 4'h7;
  localparam logic [3:0]  A_CTRL      = 4'h8;
  localparam logic [3:0]  A_FW1       = 4'h9;
  localparam logic [3:0]  A_FW2       = 4'hA;
  localparam logic [3:0]  A_FW3       = 4'hB;
  localparam logic [3:0]  A_INT_STAT  = 4'hC;
  localparam logic [3:0]  A_INT_EN    = 4'hD;
  localparam logic [3:0]  A_INT_CLR   = 4'hE;
  localparam logic [3:0]  A_LINK_STAT = 4'hF;

  // Ranges and reset values
  localparam logic [5:0]  STATION_RST  = 6'h00;
  localparam logic [5:0]  TP_SLAVE_RST = 6'h1F;
  localparam logic [5:0]  M1_NODE_RST  = 6'h15;
  localparam logic [5:0]  M1_NODE_MAX  = 6'h20;
  localparam logic [5:0]  M2_NODE_RST  = 6'h1E;
  localparam logic [5:0]  NODE_OFF     = 6'h00;
  localparam logic [5:0]  NODE_MAX     = 6'h3F;
  localparam logic [15:0] TO_RST       = 16'h0064;
  localparam logic [15:0] TO_MAX       = 16'hFA00;
  localparam logic [15:0] TO_OFF       = 16'h0000;

  typedef enum logic [2:0] {
    LNS_R20K  = 3'b000,
    LNS_R50K  = 3'b001,
    LNS_R125K = 3'b010,
    LNS_R250K = 3'b011,
    LNS_R500K = 3'b100,
    LNS_R800K = 3'b101,
    LNS_RBAD  = 3'b110,
    LNS_R1M   = 3'b111
  } lns_rate_t;

  typedef enum logic [1:0] {
    LNS_FX_UNUSED  = 2'b00,
    LNS_FX_ONBOARD = 2'b01,
    LNS_FX_EXTERN  = 2'b10,
    LNS_FX_RSVD    = 2'b11
  } lns_fx_type_t;

  // Control register bits
  localparam int          C_TP_MASTER = 0;
  localparam int          C_ARM_CONV  = 1;
  localparam int          C_BOARD_SEL = 2;

  // Event bits of the interrupt status register
  localparam int          E_BOARD = 0;
  localparam int          E_TP    = 1;
  localparam int          E_M1    = 2;
  localparam int          E_M2    = 3;
  localparam int          NEV     = 4;

  // Fault word bit positions
  localparam int          FW1_BOARD = 7;
  localparam int          FW1_M1    = 15;
  localparam int          FW2_M2    = 2;
  localparam int          FW3_TP    = 2;

  // Millisecond timebase
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          MS_NS         = 1000000;
  localparam int          TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

endpackage : lns_pkg

// File: rtl/lns_ms_tick.sv
// Millisecond tick generator for the supervision timers
`timescale 1ns/1ps
`default_nettype none
module lns_ms_tick #(
  parameter int CYCLES = lns_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Tick
  output var  logic tick
);
  import lns_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } lns_tick_st_t;

  lns_tick_st_t s_q;
  lns_tick_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 16'(CYCLES - 1)) begin
      s_d.cnt  = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : lns_ms_tick
`default_nettype wire

// File: rtl/lns_timeout.sv
// Communication break timer counting milliseconds of silence
`timescale 1ns/1ps
`default_nettype none
module lns_timeout (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Control
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        kick,
  input  wire logic [15:0] limit,
  // Result
  output var  logic        expired
);
  import lns_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        hit;
  } lns_to_st_t;

  lns_to_st_t s_q;
  lns_to_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    // Saturating at the limit gives one event per break, not a stream
    if (!run || kick || limit == TO_OFF) begin
      s_d.cnt = 16'h0000;
    end else if (tick && s_q.cnt != limit) begin
      s_d.cnt = s_q.cnt + 16'h0001;
      s_d.hit = (s_q.cnt + 16'h0001) == limit;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.hit;
endmodule : lns_timeout
`default_nettype wire

// File: testbench/lns_checker.sv
// Port assertions for the link node block
`timescale 1ns/1ps
`default_nettype none
module lns_checker
  import lns_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // Register port
  input wire logic [3:0]         reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic               reg_we,
  input wire logic               reg_re,
  input wire logic [15:0]        reg_rdata,
  // Pins and results
  input wire logic               board_present,
  input wire logic               trip,
  input wire logic               station_active,
  input wire logic [5:0]         station_node_id,
  input wire lns_pkg::lns_rate_t link_bit_rate_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_wr(a);
    reg_we && reg_addr == a;
  endsequence
  sequence s_rd(a);
    reg_re && reg_addr == a;
  endsequence
  a_rate_legal: assert property (link_bit_rate_select != LNS_RBAD)
    else $error("reserved bit-rate code");
  a_rate_write: assert property (s_wr(A_RATE) ##0 reg_wdata < 16'h0008
    && reg_wdata != 16'h0006 |=> link_bit_rate_select == $past(reg_wdata[2:0]))
    else $error("rate write lost");
  a_rate_read: assert property (s_rd(A_RATE)
    |=> reg_rdata == {13'h0000, $past(link_bit_rate_select)})
    else $error("rate read wrong");
  a_station_write: assert property (s_wr(A_STATION) ##0 reg_wdata < 16'h0040
    |=> station_node_id == $past(reg_wdata[5:0]))
    else $error("station write lost");
  a_station_keep: assert property (s_wr(A_STATION) ##0 reg_wdata > 16'h003F
    |=> $stable(station_node_id))
    else $error("station range ignored");
  a_station_act: assert property
    (station_active == ($past(station_node_id) != 6'h00))
    else $error("station active wrong");
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_trip_cause: assert property ($rose(trip) |-> !$past(board_present, 2)
    || !$past(board_present, 3) || !$past(board_present, 4))
    else $error("trip without lost board");
endmodule : lns_checker
bind lns_link_node lns_checker i_chk (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .board_present(board_present),
  .trip(trip), .station_active(station_active),
  .station_node_id(station_node_id),
  .link_bit_rate_select(link_bit_rate_select));
`default_nettype wire

// File: testbench/lns_partner.sv
// Far station model sending periodic link messages
`timescale 1ns/1ps
`default_nettype none
module lns_partner (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Control
  input  wire logic       en,
  input  wire logic [5:0] node,
  // Messages
  output var  logic       rx_valid,
  output var  logic [5:0] rx_node
);
  logic [2:0] cnt;
  // Own id is kept apart from every other station id in the bench
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt      <= 3'h0;
      rx_valid <= 1'b0;
      rx_node  <= 6'h00;
    end else begin
      cnt      <= cnt + 3'h1;
      rx_valid <= en && cnt == 3'h7;
      // Idle bus shows the inverse, never a stale id
      rx_node  <= (en && cnt == 3'h7) ? node : ~node;
    end
  end
endmodule : lns_partner
`default_nettype wire

// File: testbench/lns_link_node_tb.sv
// Self-checking bench of the link node block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module lns_link_node_tb;
  import lns_pkg::*;
  logic clk_sys, rst, reg_we, reg_re, bp, fen, rxv, trip, irq, act;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, rdat, v, e;
  logic [5:0]  fnode, rxn, sid;
  logic [31:0] seed;
  lns_rate_t   rate;
  int num_errors, num_checks;
  lns_link_node #(.TICK_CYCLES(10)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(rdat), .rx_valid(rxv), .rx_node(rxn),
    .board_present(bp), .trip(trip), .irq(irq), .station_active(act),
    .station_node_id(sid), .link_bit_rate_select(rate));
  lns_partner i_far (.clk_sys(clk_sys), .rst(rst), .en(fen),
    .node(fnode), .rx_valid(rxv), .rx_node(rxn));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [15:0] rst_val(logic [3:0] a);
    case (a)
      A_RATE: return 16'h0004;
      A_TP_TO, A_FX_TO: return TO_RST;
      A_TP_SLAVE: return 16'h001F;
      A_M1_NODE: return 16'h0015;
      A_M2_NODE: return 16'h001E;
      A_LINK_STAT: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction : rst_val
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_we <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rc(logic [3:0] a, logic [15:0] x);
    @(posedge clk_sys);
    reg_re <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1 `CHK("reg", x, rdat)
    @(posedge clk_sys);
  endtask : rc
  task automatic idle(int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    idle(20000);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {rst, reg_we, reg_re, fen} = 4'hF - 4'h7;
    {reg_addr, reg_wdata, fnode, bp} = {26'h0, 1'b1};
    seed = 32'h5E2BB4E8;
    idle(4);
    rst <= 1'b0;
    idle(4);
    for (int a = 0; a < 16; a++) rc(a[3:0], rst_val(a[3:0]));
    wr(A_RATE, 16'h0006);
    rc(A_RATE, 16'h0004);
    for (int c = 0; c < 8; c++) if (c != 6) begin
      wr(A_RATE, c[15:0]);
      rc(A_RATE, c[15:0]);
      #1 `CHK("rate", c[2:0], rate)
    end
    e = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'h0040 : 16'(xs()) & 16'h007F;
      wr(A_STATION, v);
      if (v < 16'h0040) e = v;
      rc(A_STATION, e);
      #1 `CHK("act", e != 16'h0000, act)
      `CHK("sid", e[5:0], sid)
    end
    wr(A_STATION, 16'h0001);
    wr(A_TP_TO, 16'hFA01);
    rc(A_TP_TO, TO_RST);
    wr(A_M1_NODE, 16'h0021);
    rc(A_M1_NODE, 16'h0015);
    wr(A_M1_NODE, 16'h0020);
    rc(A_M1_NODE, 16'h0020);
    wr(A_M1_NODE, 16'h0015);
    wr(A_INT_EN, 16'h000F);
    wr(A_TP_TO, 16'h0002);
    wr(A_TP_SLAVE, 16'h0005);
    fnode <= 6'h05;
    fen <= 1'b1;
    wr(A_CTRL, 16'h0001);
    idle(100);
    rc(A_FW3, 16'h0000);
    fen <= 1'b0;
    idle(60);
    rc(A_FW3, 16'h0004);
    #1 `CHK("irq", 1'b1, irq)
    wr(A_INT_CLR, 16'h000F);
    wr(A_TP_TO, 16'h0000);
    idle(60);
    rc(A_INT_STAT, 16'h0000);
    #1 `CHK("irq", 1'b0, irq)
    wr(A_CTRL, 16'h0000);
    wr(A_TP_TO, 16'h0002);
    idle(60);
    rc(A_INT_STAT, 16'h0000);
    wr(A_TP_SLAVE, 16'h0000);
    wr(A_CTRL, 16'h0001);
    idle(60);
    rc(A_INT_STAT, 16'h0000);
    wr(A_FX_TO, 16'h0002);
    wr(A_M1_TYPE, 16'h0002);
    fnode <= 6'h15;
    fen <= 1'b1;
    wr(A_CTRL, 16'h0002);
    idle(60);
    rc(A_FW2, 16'h0004);
    rc(A_FW1, 16'h0000);
    rc(A_LINK_STAT, 16'h0005);
    fen <= 1'b0;
    idle(60);
    rc(A_FW1, 16'h8000);
    rc(A_INT_STAT, 16'h000C);
    wr(A_M1_TYPE, 16'h0001);
    // Kick the exciter again so an ignored type would restart its timer
    fen <= 1'b1;
    idle(20);
    fen <= 1'b0;
    wr(A_INT_CLR, 16'h000F);
    idle(60);
    rc(A_FW1, 16'h0000);
    wr(A_CTRL, 16'h0004);
    bp <= 1'b0;
    idle(10);
    #1 `CHK("trip", 1'b1, trip)
    rc(A_FW1, 16'h0080);
    bp <= 1'b1;
    idle(5);
    wr(A_INT_CLR, 16'h000F);
    idle(3);
    #1 `CHK("trip", 1'b0, trip)
    report_and_stop();
  end
endmodule : lns_link_node_tb
`default_nettype wire
